// File: hdl/speed_search_pkg.sv
package speed_search_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned TICK_MS         = 100;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned UV_TIME_MS      = 15;
  localparam int unsigned UV_CYCLES       = CLK_HZ / 1000 * UV_TIME_MS;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SELECT  = 8'h00;
  localparam logic [7:0] OFS_CURLVL  = 8'h04;
  localparam logic [7:0] OFS_DECEL   = 8'h08;
  localparam logic [7:0] OFS_DELAY   = 8'h0C;
  localparam logic [7:0] OFS_BLOCK   = 8'h10;
  localparam logic [7:0] OFS_VRAMP   = 8'h14;
  localparam logic [7:0] OFS_CTRL    = 8'h18;
  localparam logic [7:0] OFS_STATE   = 8'h1C;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h20;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h24;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h28;

  // ----------------------------------------------------------------
  // Settings: limits and reset values, times in 0.1 s units
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_RST    = 2'h2;
  localparam logic [7:0] CUR_MAX    = 8'hC8;
  localparam logic [7:0] CUR_RST    = 8'h64;
  localparam logic [7:0] DEC_MIN    = 8'h01;
  localparam logic [7:0] DEC_MAX    = 8'h64;
  localparam logic [7:0] DEC_RST    = 8'h14;
  localparam logic [7:0] DLY_MAX    = 8'hC8;
  localparam logic [7:0] DLY_RST    = 8'h02;
  localparam logic [7:0] BLK_MIN    = 8'h01;
  localparam logic [7:0] BLK_MAX    = 8'h32;
  localparam logic [7:0] BLK_RST    = 8'h05;
  localparam logic [7:0] VR_MAX     = 8'h32;
  localparam logic [7:0] VR_RST     = 8'h03;

  // Interrupt bit positions
  localparam int unsigned IRQ_DONE  = 0;
  localparam int unsigned IRQ_UV    = 1;
  localparam int unsigned IRQ_REJ   = 2;
  localparam int unsigned IRQ_W     = 3;

  // Control register bits
  localparam int unsigned CTRL_PL_EN = 0;

  typedef enum logic [2:0] {
    ST_IDLE, ST_BLOCK, ST_DELAY, ST_SEARCH, ST_VRAMP, ST_RUN
  } seq_state_t;

  typedef struct packed {
    logic [1:0] sel;
    logic [7:0] cur;
    logic [7:0] dec;
    logic [7:0] dly;
    logic [7:0] blk;
    logic [7:0] vr;
  } settings_t;

  typedef struct packed {
    logic        block;
    logic        ramping;
    logic [15:0] freq;
    logic        dir_rev;
    logic [15:0] volt;
  } drive_out_t;

endpackage

// File: hdl/tick_div.sv
`timescale 1ns/100ps
module tick_div #(
  parameter int unsigned CYCLES = speed_search_pkg::TICK_CYCLES
) (
  input  wire logic clk,
  input  wire logic srst,
  output logic      tick
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } div_t;

  div_t s_q;
  div_t s_d;

  // ----------------------------------------------------------------
  // Free divider, one-cycle pulse per period
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == 32'(CYCLES - 1)) begin
      s_d.cnt = 32'h0000_0000;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule // tick_div

// File: hdl/motor_speed_search_restart.sv
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/100ps
// How it works
// - Find coasting motor speed and start driving from it, not zero.
// - Error outputs held off while power-loss recovery is in progress.
// - Power-loss handling off and outage over 15 ms raises undervoltage.
// - Select 0..3: search on run off/on, estimated or current mode.
// - Select setting resets to 2.
// - Estimated mode starts at computed speed and direction, then ramps.
// - Current mode starts at lost-power frequency or maximum frequency.
// - Search current level in percent, up to 200, resets to 100.
// - Current search decel rate from time, max 10.0 s, reset 2.0 s.
// - Search delay after power loss, up to 20.0 s, reset 0.2 s.
// - Output blocked for minimum time 0.1..5.0 s, reset 0.5 s.
// - Voltage ramps back after search, up to 5.0 s, reset 0.3 s.
// - Long block time delays resume until block time has elapsed.
// - Current below level ends current search, then ramp to command.
module motor_speed_search_restart #(
  parameter int unsigned UV_CYC   = speed_search_pkg::UV_CYCLES,
  parameter int unsigned TICK_CYC = speed_search_pkg::TICK_CYCLES,
  parameter int unsigned FW       = 16
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              run_cmd,
  input  wire logic              power_lost,
  input  wire logic              err_in,
  input  wire logic [FW-1:0]     freq_ref,
  input  wire logic [FW-1:0]     freq_max,
  input  wire logic [FW-1:0]     freq_est,
  input  wire logic              dir_est_rev,
  input  wire logic [7:0]        out_current_pct,
  output logic                   out_block,
  output logic [FW-1:0]          out_freq,
  output logic                   out_dir_rev,
  output logic [FW-1:0]          out_volt,
  output logic                   err_out,
  output logic                   main_undervoltage_alarm,
  output logic                   irq
);

  typedef struct packed {
    speed_search_pkg::settings_t  cfg;
    logic                         pl_en;
    logic [2:0]                   irq_st;
    logic [2:0]                   irq_en;
    logic                         wr_pend;
    logic [7:0]                   wr_addr;
    logic [31:0]                  rdata;
    speed_search_pkg::seq_state_t st;
    logic [7:0]                   tcnt;
    logic [31:0]                  uvcnt;
    logic [FW-1:0]                freq;
    logic [FW-1:0]                volt;
    logic [FW-1:0]                lost_freq;
    logic                         dir_rev;
    logic                         block;
    logic                         recov;
    logic                         err;
    logic                         uv;
    logic                         irq;
    logic [1:0]                   pl_sync;
    logic [1:0]                   run_sync;
    logic [1:0]                   err_sync;
    logic [7:0]                   cur_lat;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic   tick;
  logic   running;
  logic   ev_done;
  logic   ev_rej;
  logic   ev_uv;

  // Current sample trails the driven output by two flops
  localparam logic [7:0] SETTLE_CYC = 8'h02;

  tick_div #(.CYCLES(TICK_CYC)) u_tick (
    .clk  (clk),
    .srst (srst),
    .tick (tick)
  );

  // ----------------------------------------------------------------
  // Sequencer and bus
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    ev_done = 1'b0;
    ev_rej = 1'b0;
    ev_uv = 1'b0;
    // Control pins pass two flops before use, the current sample one
    s_d.pl_sync = {s_q.pl_sync[0], power_lost};
    s_d.run_sync = {s_q.run_sync[0], run_cmd};
    s_d.err_sync = {s_q.err_sync[0], err_in};
    s_d.cur_lat = out_current_pct;
    running = (s_q.st != speed_search_pkg::ST_IDLE);

    // AHB data phase of a write
    if (s_q.wr_pend) begin
      s_d.wr_pend = 1'b0;
      if (running && s_q.wr_addr <= speed_search_pkg::OFS_VRAMP) begin
        ev_rej = 1'b1;
      end else begin
        case (s_q.wr_addr)
          speed_search_pkg::OFS_SELECT: s_d.cfg.sel = hwdata[1:0];
          speed_search_pkg::OFS_CURLVL:
            if (hwdata[7:0] <= speed_search_pkg::CUR_MAX) begin
              s_d.cfg.cur = hwdata[7:0];
            end
          speed_search_pkg::OFS_DECEL:
            if (hwdata[7:0] >= speed_search_pkg::DEC_MIN &&
                hwdata[7:0] <= speed_search_pkg::DEC_MAX) begin
              s_d.cfg.dec = hwdata[7:0];
            end
          speed_search_pkg::OFS_DELAY:
            if (hwdata[7:0] <= speed_search_pkg::DLY_MAX) begin
              s_d.cfg.dly = hwdata[7:0];
            end
          speed_search_pkg::OFS_BLOCK:
            if (hwdata[7:0] >= speed_search_pkg::BLK_MIN &&
                hwdata[7:0] <= speed_search_pkg::BLK_MAX) begin
              s_d.cfg.blk = hwdata[7:0];
            end
          speed_search_pkg::OFS_VRAMP:
            if (hwdata[7:0] <= speed_search_pkg::VR_MAX) begin
              s_d.cfg.vr = hwdata[7:0];
            end
          speed_search_pkg::OFS_CTRL:
            s_d.pl_en = hwdata[speed_search_pkg::CTRL_PL_EN];
          speed_search_pkg::OFS_IRQ_EN: s_d.irq_en = hwdata[2:0];
          speed_search_pkg::OFS_IRQ_CLR:
            s_d.irq_st = s_q.irq_st & ~hwdata[2:0];
          default: ;
        endcase
      end
    end

    // AHB address phase; reads answer in the next cycle
    if (hsel && hready && htrans[1]) begin
      s_d.wr_pend = hwrite;
      s_d.wr_addr = haddr[7:0];
      s_d.rdata = 32'h0000_0000;
      if (!hwrite) begin
        case (haddr[7:0])
          speed_search_pkg::OFS_SELECT: s_d.rdata = {30'h0, s_q.cfg.sel};
          speed_search_pkg::OFS_CURLVL: s_d.rdata = {24'h0, s_q.cfg.cur};
          speed_search_pkg::OFS_DECEL:  s_d.rdata = {24'h0, s_q.cfg.dec};
          speed_search_pkg::OFS_DELAY:  s_d.rdata = {24'h0, s_q.cfg.dly};
          speed_search_pkg::OFS_BLOCK:  s_d.rdata = {24'h0, s_q.cfg.blk};
          speed_search_pkg::OFS_VRAMP:  s_d.rdata = {24'h0, s_q.cfg.vr};
          speed_search_pkg::OFS_CTRL:   s_d.rdata = {31'h0, s_q.pl_en};
          speed_search_pkg::OFS_STATE:
            s_d.rdata = {27'h0, s_q.recov, s_q.st, s_q.block};
          speed_search_pkg::OFS_IRQ_ST: s_d.rdata = {29'h0, s_q.irq_st};
          speed_search_pkg::OFS_IRQ_EN: s_d.rdata = {29'h0, s_q.irq_en};
          default: s_d.rdata = 32'h0000_0000;
        endcase
      end
    end

    // Undervoltage: outage longer than 15 ms with handling disabled
    if (s_q.pl_sync[1] && running && !s_q.pl_en) begin
      if (s_q.uvcnt == 32'(UV_CYC)) begin
        if (!s_q.uv) begin
          ev_uv = 1'b1;
        end
        s_d.uv = 1'b1;
      end else begin
        s_d.uvcnt = s_q.uvcnt + 32'h0000_0001;
      end
    end else if (!s_q.pl_sync[1]) begin
      s_d.uvcnt = 32'h0000_0000;
    end
    if (!s_q.run_sync[1]) begin
      s_d.uv = 1'b0;
    end

    // Phase sequencer, timers count 0.1 s ticks except the search settle count, which counts clock cycles
    case (s_q.st)
      speed_search_pkg::ST_IDLE: begin
        s_d.block = 1'b1;
        s_d.freq = '0;
        s_d.volt = '0;
        if (s_q.run_sync[1]) begin
          s_d.tcnt = 8'h00;
          if (s_q.cfg.sel[0]) begin
            s_d.lost_freq = freq_max;
            s_d.st = speed_search_pkg::ST_BLOCK;
          end else begin
            s_d.block = 1'b0;
            s_d.volt = freq_max;
            s_d.st = speed_search_pkg::ST_RUN;
          end
        end
      end
      speed_search_pkg::ST_RUN: begin
        s_d.block = 1'b0;
        s_d.freq = freq_ref;
        if (!s_q.run_sync[1] || s_q.uv) begin
          s_d.st = speed_search_pkg::ST_IDLE;
        end else if (s_q.pl_sync[1] && s_q.pl_en) begin
          s_d.lost_freq = s_q.freq;
          s_d.recov = 1'b1;
          s_d.block = 1'b1;
          s_d.tcnt = 8'h00;
          s_d.st = speed_search_pkg::ST_BLOCK;
        end
      end
      speed_search_pkg::ST_BLOCK: begin
        s_d.block = 1'b1;
        if (!s_q.run_sync[1]) begin
          s_d.st = speed_search_pkg::ST_IDLE;
        end else if (tick) begin
          s_d.tcnt = s_q.tcnt + 8'h01;
        end
        // Power must be back and block time spent before moving on
        if (s_q.run_sync[1] && !s_q.pl_sync[1] &&
            s_q.tcnt >= s_q.cfg.blk) begin
          s_d.tcnt = 8'h00;
          s_d.st = speed_search_pkg::ST_DELAY;
        end
      end
      speed_search_pkg::ST_DELAY: begin
        if (!s_q.run_sync[1]) begin
          s_d.st = speed_search_pkg::ST_IDLE;
        end else if (s_q.tcnt >= s_q.cfg.dly) begin
          s_d.tcnt = 8'h00;
          s_d.block = 1'b0;
          s_d.volt = '0;
          if (!s_q.cfg.sel[1]) begin
            s_d.freq = freq_est;
            s_d.dir_rev = dir_est_rev;
          end else begin
            s_d.freq = s_q.lost_freq;
            s_d.dir_rev = 1'b0;
          end
          s_d.st = speed_search_pkg::ST_SEARCH;
        end else if (tick) begin
          s_d.tcnt = s_q.tcnt + 8'h01;
        end
      end
      speed_search_pkg::ST_SEARCH: begin
        if (!s_q.run_sync[1]) begin
          s_d.st = speed_search_pkg::ST_IDLE;
        end else if (!s_q.cfg.sel[1] ||
                     (s_q.tcnt >= SETTLE_CYC &&
                      s_q.cur_lat < s_q.cfg.cur)) begin
          s_d.tcnt = 8'h00;
          s_d.st = speed_search_pkg::ST_VRAMP;
        end else if (s_q.tcnt < SETTLE_CYC) begin
          // Zero current from the blocked output must not end the search
          s_d.tcnt = s_q.tcnt + 8'h01;
        end else if (tick) begin
          // Step of fmax/dec per tick; floor at zero
          if (s_q.freq > freq_max / FW'(s_q.cfg.dec)) begin
            s_d.freq = s_q.freq - freq_max / FW'(s_q.cfg.dec);
          end else begin
            s_d.freq = '0;
          end
        end
      end
      speed_search_pkg::ST_VRAMP: begin
        if (!s_q.run_sync[1]) begin
          s_d.st = speed_search_pkg::ST_IDLE;
        end else if (s_q.tcnt >= s_q.cfg.vr) begin
          s_d.volt = freq_max;
          s_d.recov = 1'b0;
          ev_done = 1'b1;
          s_d.st = speed_search_pkg::ST_RUN;
        end else if (tick) begin
          s_d.tcnt = s_q.tcnt + 8'h01;
          s_d.volt = FW'((32'(freq_max) * 32'(s_q.tcnt + 8'h01)) /
                         32'(s_q.cfg.vr));
        end
      end
      default: s_d.st = speed_search_pkg::ST_IDLE;
    endcase
    if (s_d.st == speed_search_pkg::ST_IDLE) begin
      s_d.recov = 1'b0;
    end

    // Error output is masked during recovery
    s_d.err = s_q.err_sync[1] && !s_d.recov;
    // Sticky events; set beats a same-cycle clear
    s_d.irq_st = s_d.irq_st | {ev_rej, ev_uv, ev_done};
    s_d.irq = |(s_d.irq_st & s_d.irq_en);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
      s_q.cfg.sel <= speed_search_pkg::SEL_RST;
      s_q.cfg.cur <= speed_search_pkg::CUR_RST;
      s_q.cfg.dec <= speed_search_pkg::DEC_RST;
      s_q.cfg.dly <= speed_search_pkg::DLY_RST;
      s_q.cfg.blk <= speed_search_pkg::BLK_RST;
      s_q.cfg.vr <= speed_search_pkg::VR_RST;
      s_q.st <= speed_search_pkg::ST_IDLE;
      s_q.block <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs straight from flops; hreadyout and hresp are tied off
  // ----------------------------------------------------------------
  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign out_block = s_q.block;
  assign out_freq = s_q.freq;
  assign out_dir_rev = s_q.dir_rev;
  assign out_volt = s_q.volt;
  assign err_out = s_q.err;
  assign main_undervoltage_alarm = s_q.uv;
  assign irq = s_q.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_ERR_MASK: assert property (@(posedge clk) disable iff (srst)
    s_q.recov |-> !err_out) else $error("error out during recovery");
  AST_SEL_RST: assert property (@(posedge clk)
    $fell(srst) |-> s_q.cfg.sel == 2'h2) else $error("bad select reset");
  AST_BLOCK: assert property (@(posedge clk) disable iff (srst)
    s_q.st == speed_search_pkg::ST_BLOCK |-> out_block)
    else $error("output not blocked");
  AST_ORDER: assert property (@(posedge clk) disable iff (srst)
    (s_q.st == speed_search_pkg::ST_SEARCH) |->
    $past(s_q.st) inside {speed_search_pkg::ST_DELAY,
                          speed_search_pkg::ST_SEARCH})
    else $error("search entered out of order");
  AST_REJECT: assert property (@(posedge clk) disable iff (srst)
    (s_q.wr_pend && running && s_q.wr_addr <= speed_search_pkg::OFS_VRAMP)
    |=> $stable(s_q.cfg)) else $error("setting changed while running");
  AST_CUR_MAX: assert property (@(posedge clk) disable iff (srst)
    s_q.cfg.cur <= speed_search_pkg::CUR_MAX)
    else $error("current level out of range");
  AST_CUR_DONE: assert property (@(posedge clk) disable iff (srst)
    (s_q.st == speed_search_pkg::ST_SEARCH && s_q.cfg.sel[1] &&
     s_q.run_sync[1] && s_q.tcnt >= SETTLE_CYC &&
     s_q.cur_lat < s_q.cfg.cur)
    |=> s_q.st == speed_search_pkg::ST_VRAMP)
    else $error("current search did not end");
  AST_UV: assert property (@(posedge clk) disable iff (srst)
    $rose(main_undervoltage_alarm) |-> !s_q.pl_en && s_q.pl_sync[1])
    else $error("undervoltage without cause");

endmodule // motor_speed_search_restart

// File: verification/motor_model.sv
`timescale 1ns/100ps
// Coasting motor as seen through the output stage
module motor_model (
  input  wire logic        clk,
  input  wire logic [15:0] spd,
  input  wire logic        rev,
  input  wire logic        out_block,
  input  wire logic [15:0] out_freq,
  output logic [15:0]      freq_est,
  output logic             dir_est_rev,
  output logic [7:0]       out_current_pct
);
  // Sensor values settle one clock after the shaft or output changes
  initial begin
    freq_est = 16'h0000;
    dir_est_rev = 1'b0;
    out_current_pct = 8'h00;
  end
  // No current while blocked; driving above shaft speed draws it high
  always @(posedge clk) begin
    freq_est <= spd;
    dir_est_rev <= rev;
    if (out_block !== 1'b0)
      out_current_pct <= 8'h00;
    else if (out_freq > spd)
      out_current_pct <= 8'h96;
    else
      out_current_pct <= 8'h28;
  end
endmodule // motor_model

// File: verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  localparam int unsigned TK = 10;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        run_cmd = 1'b0, power_lost = 1'b0, err_in = 1'b0;
  logic        rev = 1'b0;
  logic [15:0] freq_ref = 16'h0000, freq_max = 16'h0000, spd = 16'h0000;
  logic [31:0] hrdata, rv;
  logic        hreadyout, hresp, dir_est_rev, out_block, out_dir_rev;
  logic        err_out, uv, irq;
  logic [15:0] freq_est, out_freq, out_volt, sf, vf, vv;
  logic [7:0]  cur_pct;
  logic        dph = 1'b0, dchk = 1'b0;
  logic [31:0] exp_q[$];
  logic [2:0]  seen_q[$];
  int          bad_count = 0, compares = 0, hi_cnt = 0, blk_len = 0;
  int unsigned rnd;

  // Free-running 125 MHz clock
  always #4 clk = ~clk;

  motor_speed_search_restart #(.UV_CYC(20), .TICK_CYC(TK)) dut_u (
    .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .run_cmd(run_cmd), .power_lost(power_lost), .err_in(err_in),
    .freq_ref(freq_ref), .freq_max(freq_max), .freq_est(freq_est),
    .dir_est_rev(dir_est_rev), .out_current_pct(cur_pct),
    .out_block(out_block), .out_freq(out_freq), .out_dir_rev(out_dir_rev),
    .out_volt(out_volt), .err_out(err_out),
    .main_undervoltage_alarm(uv), .irq(irq));

  motor_model motor_u (
    .clk(clk), .spd(spd), .rev(rev), .out_block(out_block),
    .out_freq(out_freq), .freq_est(freq_est), .dir_est_rev(dir_est_rev),
    .out_current_pct(cur_pct));

  // --------------------------------------------------------------
  // Checking and bus helpers
  // --------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task give_verdict;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // A hang counts as a mismatch and ends the run
  task tmo;
    bad_count++;
    $display("timeout at %0t", $time);
    give_verdict;
  endtask

  // Bounded wait for hready at a rising edge
  task hrdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) tmo;
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic c);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hrdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    dph <= !w;
    dchk <= c;
    hrdy;
    rv = hrdata;
    dph <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 1'b0);
  endtask

  // Expected read data is queued; the watcher below compares it
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000, 1'b1);
  endtask

  task wrd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    wr(a, d);
    rd(a, e);
  endtask

  // Read data watcher: oldest queued note against hrdata
  always @(posedge clk) begin
    if (dph && dchk && hreadyout === 1'b1)
      chk(hrdata, exp_q.pop_front());
  end

  // Length of the latest blocked stretch of the output
  always @(posedge clk) begin
    if (out_block === 1'b1) begin
      hi_cnt <= hi_cnt + 1;
    end else begin
      if (hi_cnt != 0) blk_len <= hi_cnt;
      hi_cnt <= 0;
    end
  end

  // Polls the state until run, logging each new phase; polls are far
  // shorter than one tick, so only a one-cycle search can be missed
  task trace;
    int n;
    seen_q = {};
    for (n = 0; n < 400; n++) begin
      bus(1'b0, speed_search_pkg::OFS_STATE, 32'h0000_0000, 1'b0);
      if (rv[4] === 1'b1 && rv[3:1] < 3'd3) chk(err_out, 0);
      if (rv[3:1] != 3'd0 && (seen_q.size() == 0 || seen_q[$] != rv[3:1]))
      begin
        seen_q.push_back(rv[3:1]);
        if (rv[3:1] == 3'd3) sf = out_freq;
        if (rv[3:1] == 3'd4) vf = out_freq;
        if (rv[3:1] == 3'd4) vv = out_volt;
      end
      if (rv[3:1] == 3'd5) return;
    end
    tmo;
  endtask

  task full_seq;
    int i;
    chk(seen_q.size(), 5);
    for (i = 0; i < 5; i++) chk(seen_q[i], i + 1);
  endtask

  task stop_run;
    int n;
    @(posedge clk) run_cmd <= 1'b0;
    for (n = 0; n < 100; n++) begin
      bus(1'b0, speed_search_pkg::OFS_STATE, 32'h0000_0000, 1'b0);
      if (rv[3:1] == 3'd0) return;
    end
    tmo;
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    rnd = $urandom(96);
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk(out_block, 1);
    rd(speed_search_pkg::OFS_SELECT, 32'h0000_0002);
    rd(speed_search_pkg::OFS_CURLVL, 32'h0000_0064);
    rd(speed_search_pkg::OFS_DECEL, 32'h0000_0014);
    rd(speed_search_pkg::OFS_DELAY, 32'h0000_0002);
    rd(speed_search_pkg::OFS_BLOCK, 32'h0000_0005);
    rd(speed_search_pkg::OFS_VRAMP, 32'h0000_0003);
    rd(speed_search_pkg::OFS_CTRL, 32'h0000_0000);
    wrd(8'h2C, 32'h0000_00FF, 32'h0000_0000);
    // Limits of each setting: current level top value kept, one beyond a limit ignored
    wrd(speed_search_pkg::OFS_CURLVL, 32'h0000_00C8, 32'h0000_00C8);
    wrd(speed_search_pkg::OFS_CURLVL, 32'h0000_00C9, 32'h0000_00C8);
    wrd(speed_search_pkg::OFS_DECEL, 32'h0000_0000, 32'h0000_0014);
    wrd(speed_search_pkg::OFS_DECEL, 32'h0000_0065, 32'h0000_0014);
    wrd(speed_search_pkg::OFS_DELAY, 32'h0000_00C9, 32'h0000_0002);
    wrd(speed_search_pkg::OFS_BLOCK, 32'h0000_0000, 32'h0000_0005);
    wrd(speed_search_pkg::OFS_BLOCK, 32'h0000_0033, 32'h0000_0005);
    wrd(speed_search_pkg::OFS_VRAMP, 32'h0000_0033, 32'h0000_0003);
    // Working values: phases of two ticks, search step of a tenth
    wrd(speed_search_pkg::OFS_CURLVL, 32'h0000_0064, 32'h0000_0064);
    wrd(speed_search_pkg::OFS_DECEL, 32'h0000_000A, 32'h0000_000A);
    wrd(speed_search_pkg::OFS_DELAY, 32'h0000_0002, 32'h0000_0002);
    wrd(speed_search_pkg::OFS_BLOCK, 32'h0000_0002, 32'h0000_0002);
    wrd(speed_search_pkg::OFS_VRAMP, 32'h0000_0002, 32'h0000_0002);
    @(posedge clk);
    freq_max <= 16'h6000 + 16'($urandom % 4096);
    spd <= 16'h1800 + 16'($urandom % 4096);
    rev <= 1'($urandom % 2);
    @(posedge clk);
    freq_ref <= spd;
    // Every select code in turn
    for (int s = 0; s < 4; s++) begin
      wrd(speed_search_pkg::OFS_SELECT, s, s);
      @(posedge clk) run_cmd <= 1'b1;
      trace;
      chk(seen_q[0], s[0] ? 1 : 5);
      if (s == 1) begin
        chk(vf, spd);
        chk(out_dir_rev, rev);
      end
      if (s == 3) begin
        full_seq;
        chk(sf > spd, 1);
        chk(vf <= spd && 32'(vf) + 32'(freq_max) / 10 >= 32'(spd), 1);
        chk(vv < out_volt, 1);
        wr(speed_search_pkg::OFS_CURLVL, 32'h0000_0032);
        chk(hresp, 0);
        rd(speed_search_pkg::OFS_CURLVL, 32'h0000_0064);
        rd(speed_search_pkg::OFS_IRQ_ST, 32'h0000_0005);
        wr(speed_search_pkg::OFS_IRQ_EN, 32'h0000_0004);
        repeat (2) @(posedge clk);
        chk(irq, 1);
        wr(speed_search_pkg::OFS_IRQ_CLR, 32'h0000_0004);
        repeat (2) @(posedge clk);
        chk(irq, 0);
        rd(speed_search_pkg::OFS_IRQ_ST, 32'h0000_0001);
      end
      stop_run;
    end
    // Short outage with handling on and a block time longer than it
    wrd(speed_search_pkg::OFS_BLOCK, 32'h0000_0004, 32'h0000_0004);
    wr(speed_search_pkg::OFS_CTRL, 32'h0000_0001);
    wr(speed_search_pkg::OFS_SELECT, 32'h0000_0003);
    @(posedge clk) run_cmd <= 1'b1;
    trace;
    err_in <= 1'b1;
    repeat (4) @(posedge clk);
    chk(err_out, 1);
    // Run command stays held through the whole outage
    power_lost <= 1'b1;
    repeat (5) @(posedge clk);
    power_lost <= 1'b0;
    trace;
    full_seq;
    chk(blk_len >= 3 * TK + 1, 1);
    repeat (4) @(posedge clk);
    chk(err_out, 1);
    err_in <= 1'b0;
    stop_run;
    // Handling off: a 10-cycle outage passes, a 30-cycle one alarms
    wr(speed_search_pkg::OFS_CTRL, 32'h0000_0000);
    wr(speed_search_pkg::OFS_SELECT, 32'h0000_0002);
    @(posedge clk) run_cmd <= 1'b1;
    trace;
    power_lost <= 1'b1;
    repeat (10) @(posedge clk);
    power_lost <= 1'b0;
    repeat (6) @(posedge clk);
    chk(uv, 0);
    power_lost <= 1'b1;
    repeat (30) @(posedge clk);
    power_lost <= 1'b0;
    repeat (2) @(posedge clk);
    chk(uv, 1);
    rd(speed_search_pkg::OFS_IRQ_ST, 32'h0000_0003);
    wr(speed_search_pkg::OFS_IRQ_EN, 32'h0000_0002);
    repeat (2) @(posedge clk);
    chk(irq, 1);
    @(posedge clk) run_cmd <= 1'b0;
    repeat (6) @(posedge clk);
    chk(uv, 0);
    give_verdict;
  end
endmodule // tb_top
